/* File: hdl/offset_gain_regs.vh */
// register map, field positions and reset values of the offset/gain correction block
`ifndef OFFSET_GAIN_REGS_VH
`define OFFSET_GAIN_REGS_VH
`define OFS_ADDR 12'h000
`define GAIN_A_ADDR 12'h004
`define GAIN_B_ADDR 12'h008
`define CTRL_ADDR 12'h00c
`define STAT_ADDR 12'h010
`define LAST_A_ADDR 12'h014
`define LAST_B_ADDR 12'h018
`define OFS_RST 12'h000
`define GAIN_RST 7'h00
`define OFS_SIGN_BIT 11
`define GAIN_SIGN_BIT 6
`define CTRL_BYPASS_BIT 0
`define STAT_CAL_BIT 0
`define STAT_AMP_BIT 1
`define STAT_CNT_LSB 8
`define GAIN_SHIFT 12
`endif

/* File: hdl/offset_gain_correction.v */
// offset and per-channel gain correction of dual 12-bit conversion results, with apb registers
//
// Contract
// - offset register is twelve bits wide
// - manual offset applies without calibration input
// - each channel has its own gain register
// - gain register: sign plus six-bit magnitude
// - result scaled by one plus/minus x/4096
// - sign zero subtracts x/4096 from one
// - sign one adds x/4096 to one
// - all-zero gain register gives unity multiplier
// - stored offset removed from every result while bypass is clear
// - offset kept when amplifier gain changes
`timescale 1ns/1ps
`default_nettype none
`include "offset_gain_regs.vh"

module offset_gain_correction #(
  parameter WIDTH = 12
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // raw conversion results
  input wire i_raw_valid,
  input wire [WIDTH-1:0] i_raw_a,
  input wire [WIDTH-1:0] i_raw_b,
  input wire i_cal_request,
  input wire [3:0] i_input_amplifier_gain,
  // corrected results
  output reg o_result_valid,
  output reg [WIDTH-1:0] o_result_line_a,
  output reg [WIDTH-1:0] o_result_line_b
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [11:0] offset_correction_ff;
  reg [6:0] gain_correction_a_ff;
  reg [6:0] gain_correction_b_ff;
  reg bypass_ff;
  reg [3:0] amp_at_load_ff;
  reg amp_changed_ff;
  reg [15:0] conv_count_ff;
  reg [WIDTH-1:0] last_raw_a_ff;
  reg [WIDTH-1:0] last_raw_b_ff;
  reg cal_s1_ff;
  reg cal_s2_ff;
  reg cal_s3_ff;
  reg cal_level_ff;
  wire wr_en;
  wire rd_en;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;

  // ---------------------------------------------------------------
  // correction arithmetic
  // ---------------------------------------------------------------
  // offset removal then gain scaling, saturated
  function [WIDTH-1:0] correct;
    input [WIDTH-1:0] raw;
    input [11:0] ofs;
    input [6:0] gain;
    reg signed [15:0] sum;
    reg signed [31:0] prod;
    reg signed [31:0] scaled;
    begin
      // sign-magnitude offset subtracted from result
      if (ofs[`OFS_SIGN_BIT]) begin
        sum = $signed({4'h0, raw}) + $signed({5'h00, ofs[10:0]});
      end else begin
        sum = $signed({4'h0, raw}) - $signed({5'h00, ofs[10:0]});
      end
      // x/4096 correction term: plus on sign one, minus on sign zero
      // every operand kept signed so a negative sum floors, not wraps
      prod = sum * $signed({10'h000, gain[5:0]});
      if (gain[`GAIN_SIGN_BIT]) begin
        scaled = $signed({{16{sum[15]}}, sum}) + (prod >>> `GAIN_SHIFT);
      end else begin
        scaled = $signed({{16{sum[15]}}, sum}) - (prod >>> `GAIN_SHIFT);
      end
      // clamp to output range
      if (scaled < 0) begin
        correct = {WIDTH{1'b0}};
      end else if (scaled > $signed((32'h1 << WIDTH) - 1)) begin
        correct = {WIDTH{1'b1}};
      end else begin
        correct = scaled[WIDTH-1:0];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign wr_en = i_psel & i_penable & i_pwrite & ~o_pready;
  assign rd_en = i_psel & i_penable & ~i_pwrite & ~o_pready;

  // read mux and unmapped address error
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (i_paddr)
      `OFS_ADDR: nxt_prdata = {20'h00000, offset_correction_ff};
      `GAIN_A_ADDR: nxt_prdata = {25'h0000000, gain_correction_a_ff};
      `GAIN_B_ADDR: nxt_prdata = {25'h0000000, gain_correction_b_ff};
      `CTRL_ADDR: nxt_prdata = {31'h00000000, bypass_ff};
      `STAT_ADDR: nxt_prdata = {8'h00, conv_count_ff, 6'h00, amp_changed_ff, cal_level_ff};
      `LAST_A_ADDR: nxt_prdata = {{(32-WIDTH){1'b0}}, last_raw_a_ff};
      `LAST_B_ADDR: nxt_prdata = {{(32-WIDTH){1'b0}}, last_raw_b_ff};
      default: nxt_prdata[0] = 1'b0;
    endcase
    case (i_paddr)
      `OFS_ADDR, `GAIN_A_ADDR, `GAIN_B_ADDR, `CTRL_ADDR, `STAT_ADDR, `LAST_A_ADDR, `LAST_B_ADDR: nxt_pslverr = 1'b0;
      default: nxt_pslverr = 1'b1;
    endcase
  end

  // three-stage synchroniser, level taken when last two agree
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_s1_ff <= 1'b0;
      cal_s2_ff <= 1'b0;
      cal_s3_ff <= 1'b0;
      cal_level_ff <= 1'b0;
    end else begin
      cal_s1_ff <= i_cal_request;
      cal_s2_ff <= cal_s1_ff;
      cal_s3_ff <= cal_s2_ff;
      if (cal_s2_ff == cal_s3_ff) begin
        cal_level_ff <= cal_s3_ff;
      end
    end
  end

  // bus answer, one wait state
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & nxt_pslverr;
      if (rd_en) begin
        o_prdata <= nxt_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // manual loads take effect regardless of cal request
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      offset_correction_ff <= `OFS_RST;
      gain_correction_a_ff <= `GAIN_RST;
      gain_correction_b_ff <= `GAIN_RST;
      bypass_ff <= 1'b0;
      amp_at_load_ff <= 4'h0;
      amp_changed_ff <= 1'b0;
    end else begin
      if (wr_en && i_paddr == `OFS_ADDR) begin
        offset_correction_ff <= i_pwdata[11:0];
        amp_at_load_ff <= i_input_amplifier_gain;
      end
      if (wr_en && i_paddr == `GAIN_A_ADDR) begin
        gain_correction_a_ff <= i_pwdata[6:0];
      end
      if (wr_en && i_paddr == `GAIN_B_ADDR) begin
        gain_correction_b_ff <= i_pwdata[6:0];
      end
      if (wr_en && i_paddr == `CTRL_ADDR) begin
        bypass_ff <= i_pwdata[`CTRL_BYPASS_BIT];
      end
      // offset stays; only flag that amp gain moved since load
      if (wr_en && i_paddr == `OFS_ADDR) begin
        amp_changed_ff <= 1'b0;
      end else if (i_input_amplifier_gain != amp_at_load_ff) begin
        amp_changed_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // result path
  // ---------------------------------------------------------------
  // one-cycle corrected result per raw pair
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_result_valid <= 1'b0;
      o_result_line_a <= {WIDTH{1'b0}};
      o_result_line_b <= {WIDTH{1'b0}};
      last_raw_a_ff <= {WIDTH{1'b0}};
      last_raw_b_ff <= {WIDTH{1'b0}};
      conv_count_ff <= 16'h0000;
    end else begin
      o_result_valid <= i_raw_valid;
      if (i_raw_valid) begin
        last_raw_a_ff <= i_raw_a;
        last_raw_b_ff <= i_raw_b;
        conv_count_ff <= conv_count_ff + 16'h0001;
        if (bypass_ff) begin
          o_result_line_a <= i_raw_a;
          o_result_line_b <= i_raw_b;
        end else begin
          o_result_line_a <= correct(i_raw_a, offset_correction_ff, gain_correction_a_ff);
          o_result_line_b <= correct(i_raw_b, offset_correction_ff, gain_correction_b_ff);
        end
      end
    end
  end

endmodule // offset_gain_correction
`default_nettype wire

/* File: tb/ogc_sva.sv */
// port checks for the correction block
`timescale 1ns/1ps
`default_nettype none
module ogc_sva #(parameter WIDTH = 12) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_raw_valid,
  input wire logic o_result_valid,
  input wire logic [WIDTH-1:0] o_result_line_a,
  input wire logic [WIDTH-1:0] o_result_line_b
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_rdy_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late ready");
  a_rdy_cause: assert property (o_pready |-> $past(i_psel && i_penable)) else $error("stray ready");
  a_rdy_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
  a_err_unmapped: assert property (o_pready && ($past(i_paddr) > 12'h018 || $past(i_paddr[1:0]) != 2'b00)
    |-> o_pslverr) else $error("no err");
  a_err_mapped: assert property (o_pready && $past(i_paddr) <= 12'h018 && $past(i_paddr[1:0]) == 2'b00
    |-> !o_pslverr) else $error("bad err");
  a_err_with_rdy: assert property (o_pslverr |-> o_pready) else $error("err alone");
  a_res_follow: assert property (i_raw_valid |=> o_result_valid) else $error("no result");
  a_res_cause: assert property (o_result_valid |-> $past(i_raw_valid)) else $error("stray result");
  a_res_hold: assert property (!o_result_valid |-> $stable({o_result_line_a, o_result_line_b}))
    else $error("result moved");
  c_err: cover property (o_pslverr);
  c_low: cover property (o_result_valid && o_result_line_a == 0);
  c_high: cover property (o_result_valid && &o_result_line_a);
endmodule // ogc_sva
bind offset_gain_correction ogc_sva #(.WIDTH(WIDTH)) i_sva (.i_ref_clk, .i_rst, .i_psel, .i_penable,
  .i_paddr, .o_pready, .o_pslverr, .i_raw_valid, .o_result_valid, .o_result_line_a, .o_result_line_b);
`default_nettype wire

/* File: tb/host_capture.sv */
// host port model: takes both result lines at one edge
`timescale 1ns/1ps
`default_nettype none
module host_capture (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [11:0] i_line_a,
  input wire logic [11:0] i_line_b,
  output logic [11:0] o_cap_a,
  output logic [11:0] o_cap_b
);
  // one strobe captures both lines together
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cap_a <= 12'h000;
      o_cap_b <= 12'h000;
    end else if (i_valid) begin
      o_cap_a <= i_line_a;
      o_cap_b <= i_line_b;
    end
  end
endmodule // host_capture
`default_nettype wire

/* File: tb/tb_top.sv */
// bench for the offset/gain correction block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_ref_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, rv = 0, cal = 0, pready, perr, ov, err;
  logic [11:0] paddr = 12'h000, ra = 12'h000, rb = 12'h000, ca, cb, la, lb, ofs;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] amp = 4'h0;
  logic [6:0] gt [6] = '{7'h00, 7'h01, 7'h3f, 7'h40, 7'h41, 7'h7f};
  int errors = 0, n_compared = 0, cyc = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  offset_gain_correction #(.WIDTH(12)) i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_raw_valid(rv), .i_raw_a(ra), .i_raw_b(rb),
    .i_cal_request(cal), .i_input_amplifier_gain(amp), .o_result_valid(ov), .o_result_line_a(la),
    .o_result_line_b(lb));
  host_capture i_host (.i_clk(i_ref_clk), .i_rst(i_rst), .i_valid(ov), .i_line_a(la), .i_line_b(lb),
    .o_cap_a(ca), .o_cap_b(cb));
  task summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // apb cycle: setup, access, hold until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    pen <= 1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 0;
    pen <= 0;
  endtask
  // expected corrected value, clamped
  function automatic logic [11:0] fx(input int r, input logic [11:0] o, input logic [6:0] g);
    int s, m, x, t;
    m = o[10:0];
    x = g[5:0];
    s = o[11] ? r + m : r - m;
    t = (s * x) >>> 12;
    s = g[6] ? s + t : s - t;
    return s < 0 ? 12'h000 : s > 4095 ? 12'hfff : s[11:0];
  endfunction
  // one conversion pair, seen through the host model
  task conv(input logic [11:0] a, b, ea, eb);
    @(posedge i_ref_clk);
    rv <= 1;
    ra <= a;
    rb <= b;
    @(posedge i_ref_clk);
    rv <= 0;
    #1 chk("valid", 1, ov);
    @(posedge i_ref_clk);
    #1 chk("line_a", ea, ca);
    chk("line_b", eb, cb);
  endtask
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 0;
    for (int k = 0; k < 3; k++) begin
      apb(0, 12'(4 * k), 0);
      chk("reset", 0, rd);
    end
    conv(12'h7a5, 12'h05a, 12'h7a5, 12'h05a);
    conv(12'd16, 12'd18, 12'd16, 12'd18);
    ofs = (ca + cb) >> 1;
    apb(1, 12'h000, {20'h0, ofs});
    conv(12'd17, 12'd17, 12'd0, 12'd0);
    apb(1, 12'h000, 32'hffff_f810);
    apb(0, 12'h000, 0);
    chk("offset", 32'h810, rd);
    conv(12'd1000, 12'hfff, 12'd1016, 12'hfff);
    amp <= 4'h5;
    conv(12'd1000, 12'd7, 12'd1016, 12'd23);
    conv(12'hfff, 12'h000, 12'hfff, 12'd16);
    for (int k = 0; k < 6; k++) begin
      apb(1, 12'h004, {25'h0, gt[k]});
      apb(1, 12'h008, {25'h0, gt[k] ^ 7'h40});
      apb(0, 12'h004, 0);
      chk("gain_a", {25'h0, gt[k]}, rd);
      conv(12'hfe0, 12'h400, fx(4064, 12'h810, gt[k]), fx(1024, 12'h810, gt[k] ^ 7'h40));
    end
    apb(1, 12'h000, 32'h010);
    conv(12'd5, 12'hfff, 12'd0, fx(4095, 12'h010, 7'h3f));
    // bypass passes raw codes, last raw pair kept
    apb(1, 12'h00c, 32'h1);
    conv(12'd5, 12'hfff, 12'd5, 12'hfff);
    apb(0, 12'h014, 0);
    chk("last_a", 32'h5, rd);
    apb(0, 12'h018, 0);
    chk("last_b", 32'hfff, rd);
    // status: 14 conversions, amp moved, cal pin synced high
    @(posedge i_ref_clk);
    amp <= 4'h3;
    cal <= 1;
    repeat (4) @(posedge i_ref_clk);
    apb(0, 12'h010, 0);
    chk("status", 32'h0000_0e03, rd);
    apb(1, 12'h100, 32'h5a);
    chk("wr_err", 1, err);
    apb(0, 12'h100, 0);
    chk("rd_err", 1, err);
    chk("rd_data", 0, rd);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
